// ===== design/vir_pkg.sv
// Purpose: constants for the version-identification responder
// Assumes: byte-serial command and response streams
// Notes:   byte positions are offsets within a packet
package vir_pkg;
  localparam logic [7:0] CMD_VERSION_ID    = 8'h15;
  localparam logic [7:0] CMD_CAPABILITIES  = 8'h16;
  localparam logic [7:0] RSP_VERSION_ID    = 8'h95;
  localparam logic [7:0] CODE_NONE         = 8'h00;
  localparam logic [7:0] SUFFIX_UNUSED     = 8'h00;
  localparam logic [7:0] UPDATE_ABSENT     = 8'hFF;
  localparam logic [3:0] NIBBLE_IGNORE     = 4'hF;
  localparam logic [15:0] PCI_ID_UNUSED    = 16'h0000;
  localparam logic [31:0] MFR_UNUSED       = 32'hFFFF_FFFF;
  localparam int          NAME_LEN         = 12;
  // request layout
  localparam logic [5:0] REQ_TYPE_POS      = 6'h04;
  // response layout
  localparam logic [5:0] POS_CODES         = 6'h10;
  localparam logic [5:0] POS_VERSION       = 6'h14;
  localparam logic [5:0] POS_SUFFIX2       = 6'h1B;
  localparam logic [5:0] POS_NAME          = 6'h1C;
  localparam logic [5:0] POS_FW_VERSION    = 6'h28;
  localparam logic [5:0] POS_PCI_IDS       = 6'h2C;
  localparam logic [5:0] POS_MFR           = 6'h34;
  localparam logic [5:0] POS_LAST          = 6'h37;
  typedef enum logic [1:0] {
    VIR_IDLE  = 2'b00,
    VIR_HOLD  = 2'b01,
    VIR_SEND  = 2'b10
  } vir_state_e;
endpackage

// ===== design/vir_responder.sv
// Purpose: recognise version-id and capability requests, stream version-id body
// Assumes: request bytes arrive one per cycle with a start marker; rsp_ready from framer
// Notes:   header, checksum and capability body come from neighbouring blocks
//          each body byte takes at least two cycles: the hold cycle lets the rom register
//          settle on the new address, trading half the byte rate for a
//          registered data output
//          identity inputs are read live, so they must stay put during a response
//
// Notes on behaviour
// - version request is code 0x15, header plus checksum and pad only.
// - every valid version request is accepted, answered with type 0x95; the code drops one whose done strobe arrives mid-response.
// - only generic response and reason codes are returned.
// - response carries the claimed protocol version.
// - major, minor, update bytes are two packed bcd digits.
// - suffix bytes hold optional latin-1 characters.
// - suffix 0x00 means unused; first suffix filled before second.
// - upper nibble 0xF marks a single-digit bcd byte.
// - update 0xFF means absent; major and minor never 0xFF.
// - firmware name holds latin-1 characters.
// - name is left-justified, first character in the top byte.
// - short name ends with 0x00; full-length name needs none.
// - bytes after the terminator are don't-care to the reader.
// - firmware version is one 32-bit field of four hex bytes.
// - without shared host interface, all four identifiers are zero.
// - with shared host interface, identifiers carry its values.
// - manufacturer is 32-bit enterprise number, all ones when unused.
// - capability request is code 0x16, header plus checksum and pad.
`timescale 1ns/1ps
`default_nettype none
module vir_responder (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // request stream, already checked by the receive path
  input  wire logic        req_valid,
  input  wire logic        req_start,
  input  wire logic [7:0]  req_byte,
  input  wire logic        req_done,
  input  wire logic        req_error,
  // controller identity, held static
  input  wire logic [7:0]  ver_major,
  input  wire logic [7:0]  ver_minor,
  input  wire logic [7:0]  ver_update,
  input  wire logic [7:0]  first_suffix_char,
  input  wire logic [7:0]  second_suffix_char,
  input  wire logic [95:0] fw_name,
  input  wire logic [31:0] fw_version,
  input  wire logic        host_if_shared,
  input  wire logic [15:0] host_device_ident,
  input  wire logic [15:0] host_vendor_ident,
  input  wire logic [15:0] host_subsystem_ident,
  input  wire logic [15:0] host_subsystem_vendor_ident,
  input  wire logic        mfr_used,
  input  wire logic [31:0] mfr_enterprise,
  // response stream toward the framer
  input  wire logic        rsp_ready,
  output logic             rsp_valid,
  output logic      [7:0]  rsp_byte,
  output logic      [5:0]  rsp_pos,
  output logic             rsp_last,
  // status
  output logic      [7:0]  rsp_type,
  output logic             cap_request,
  output logic             version_fault
);
  vir_pkg::vir_state_e state_reg, state_next;
  logic [5:0] pos_reg, pos_next;
  logic [5:0] rx_pos_reg, rx_pos_next;
  logic [7:0] cmd_reg, cmd_next;
  logic       cap_reg, cap_next;
  logic [7:0] type_reg, type_next;
  logic [7:0] upd_fix, sfx1_fix, sfx2_fix;
  logic [95:0] name_fix;
  logic [63:0] pci_word;
  logic [31:0] mfr_word;
  logic [7:0]  rom_data;
  logic [39:0] version_word;
  logic [23:0] bcd_bytes;
  logic [2:0]  bcd_flag;
  logic [63:0] pci_in;
  logic [vir_pkg::NAME_LEN:0] null_seen;

  // update absent
  // illegal 0xFF in major/minor is flagged rather than silently sent
  assign upd_fix = ver_update;
  // suffix ordering: a second suffix without a first is dropped
  always_comb begin
    sfx1_fix = first_suffix_char;
    sfx2_fix = (first_suffix_char == vir_pkg::SUFFIX_UNUSED) ?
               vir_pkg::SUFFIX_UNUSED : second_suffix_char;
  end
  // packed in send order, major first and second suffix last
  assign version_word = {ver_major, ver_minor, upd_fix, sfx1_fix, sfx2_fix};

  // single digit
  // slot 2 is major, slot 1 minor, slot 0 update
  assign bcd_bytes = {ver_major, ver_minor, ver_update};
  for (genvar g = 0; g < 3; g++) begin : g_bcd
    logic [7:0] b;
    logic       hi_ok;
    logic       lo_ok;
    assign b           = bcd_bytes[8*g +: 8];
    assign hi_ok       = (b[7:4] <= 4'h9) || (b[7:4] == vir_pkg::NIBBLE_IGNORE);
    assign lo_ok       = (b[3:0] <= 4'h9);
    assign bcd_flag[g] = !(hi_ok && lo_ok);
  end

  // absent update
  // an absent update is the only byte allowed to be non-bcd
  assign version_fault = (ver_major == vir_pkg::UPDATE_ABSENT) ||
                         (ver_minor == vir_pkg::UPDATE_ABSENT) ||
                         bcd_flag[2] || bcd_flag[1] ||
                         ((ver_update != vir_pkg::UPDATE_ABSENT) && bcd_flag[0]);

  // tail fill: bytes after the first null are forced to zero
  // so a stale tail never leaks to the management side
  assign null_seen[0] = 1'b0;
  for (genvar g = 0; g < vir_pkg::NAME_LEN; g++) begin : g_name
    logic [7:0] ch;
    assign ch                      = fw_name[95 - 8*g -: 8];
    assign name_fix[95 - 8*g -: 8] = null_seen[g] ? 8'h00 : ch;
    assign null_seen[g + 1]        = null_seen[g] || (ch == 8'h00);
  end

  // shared ids
  // device ident sits in the top slot, subsystem vendor in the bottom
  assign pci_in = {host_device_ident, host_vendor_ident, host_subsystem_ident,
                   host_subsystem_vendor_ident};
  for (genvar g = 0; g < 4; g++) begin : g_pci
    assign pci_word[16*g +: 16] = host_if_shared ? pci_in[16*g +: 16] : vir_pkg::PCI_ID_UNUSED;
  end

  assign mfr_word = mfr_used ? mfr_enterprise : vir_pkg::MFR_UNUSED;

  vir_rom u_rom (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .addr         (pos_next),
    .version_word (version_word),
    .name_word    (name_fix),
    .fw_version   (fw_version),
    .pci_ids      (pci_word),
    .mfr_id       (mfr_word),
    .data         (rom_data)
  );

  // request parser
  always_comb begin
    rx_pos_next = rx_pos_reg;
    cmd_next    = cmd_reg;
    if (req_valid) begin
      if (req_start) begin
        rx_pos_next = 6'd1;
        cmd_next    = 8'h00;
      end else begin
        if (rx_pos_reg == vir_pkg::REQ_TYPE_POS) begin
          cmd_next = req_byte;
        end
        if (rx_pos_reg != 6'h3F) begin
          rx_pos_next = rx_pos_reg + 6'd1;
        end
      end
    end
    // a finished request consumes its code, so a stray done strobe
    // cannot answer the previous command a second time
    if (req_done) begin
      cmd_next = 8'h00;
    end
  end

  // response sequencer
  // idle waits for a clean done strobe; hold lets the rom register load the
  // byte at pos_next; send offers it until the framer takes it
  always_comb begin
    state_next = state_reg;
    pos_next   = pos_reg;
    cap_next   = 1'b0;
    type_next  = type_reg;
    case (state_reg)
      vir_pkg::VIR_IDLE: begin
        if (req_done && !req_error) begin
          if (cmd_reg == vir_pkg::CMD_VERSION_ID) begin
            state_next = vir_pkg::VIR_HOLD;
            pos_next   = vir_pkg::POS_CODES;
            type_next  = vir_pkg::RSP_VERSION_ID;
          end
          if (cmd_reg == vir_pkg::CMD_CAPABILITIES) begin
            cap_next = 1'b1;
          end
        end
      end
      vir_pkg::VIR_HOLD: begin
        state_next = vir_pkg::VIR_SEND;
      end
      vir_pkg::VIR_SEND: begin
        if (rsp_ready) begin
          if (pos_reg == vir_pkg::POS_LAST) begin
            state_next = vir_pkg::VIR_IDLE;
          end else begin
            pos_next   = pos_reg + 6'd1;
            state_next = vir_pkg::VIR_HOLD;
          end
        end
      end
      default: begin
        state_next = vir_pkg::VIR_IDLE;
      end
    endcase
  end

  // parser registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_pos_reg <= 6'h00;
      cmd_reg    <= 8'h00;
    end else begin
      rx_pos_reg <= rx_pos_next;
      cmd_reg    <= cmd_next;
    end
  end

  // sequencer registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= vir_pkg::VIR_IDLE;
      pos_reg   <= 6'h00;
      cap_reg   <= 1'b0;
      type_reg  <= 8'h00;
    end else begin
      state_reg <= state_next;
      pos_reg   <= pos_next;
      cap_reg   <= cap_next;
      type_reg  <= type_next;
    end
  end

  // handshake outputs decode the state register; the data byte is registered
  assign rsp_valid   = (state_reg == vir_pkg::VIR_SEND);
  assign rsp_byte    = rom_data;
  assign rsp_pos     = pos_reg;
  assign rsp_last    = rsp_valid && (pos_reg == vir_pkg::POS_LAST);
  assign rsp_type    = type_reg;
  assign cap_request = cap_reg;
endmodule
`default_nettype wire

// ===== design/vir_rom.sv
// Purpose: registered byte lookup of the fixed response body
// Assumes: identity inputs are static while a response is sent
// Notes:   bytes 0-15 and 56-59 are left to header and checksum blocks
`timescale 1ns/1ps
`default_nettype none
module vir_rom (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [5:0]  addr,
  input  wire logic [39:0] version_word,
  input  wire logic [95:0] name_word,
  input  wire logic [31:0] fw_version,
  input  wire logic [63:0] pci_ids,
  input  wire logic [31:0] mfr_id,
  output logic      [7:0]  data
);
  logic [7:0]   data_next;
  logic [447:0] body;
  // body holds bytes 16..71 msb first; byte 16 at the top
  always_comb begin
    body = '0;
    body[447:416] = {vir_pkg::CODE_NONE, vir_pkg::CODE_NONE,
                     vir_pkg::CODE_NONE, vir_pkg::CODE_NONE};
    body[415:384] = version_word[39:8];
    body[383:352] = {24'h00_0000, version_word[7:0]};
    body[351:256] = name_word;
    body[255:224] = fw_version;
    body[223:160] = pci_ids;
    body[159:128] = mfr_id;
    data_next = 8'h00;
    if (addr >= vir_pkg::POS_CODES && addr <= vir_pkg::POS_LAST) begin
      data_next = body[447 - 8*(32'(addr) - 16) -: 8];
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data <= 8'h00;
    end else begin
      data <= data_next;
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// Purpose: self-checking bench for the version-id responder
// Assumes: partner model drives requests and sinks the body
// Notes:   rows hold version bytes as given and as sent
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [39:0] vin;
    logic [39:0] vexp;
    logic        shared;
    logic        mfr;
  } vir_row_s;
  localparam vir_row_s ROWS [4] = '{
    '{40'hF3_F710_4100, 40'hF3_F710_4100, 1'b1, 1'b1},
    '{40'h10_01F7_0000, 40'h10_01F7_0000, 1'b0, 1'b0},
    '{40'hF1_F0FF_4142, 40'hF1_F0FF_4142, 1'b1, 1'b0},
    '{40'hF1_F0FF_0042, 40'hF1_F0FF_0000, 1'b0, 1'b1}};
  logic ref_clk = 1'b0, rst = 1'b1, host_if_shared, mfr_used, cap_request, version_fault;
  logic req_valid, req_start, req_done, req_error, rsp_ready, rsp_valid, rsp_last;
  logic [7:0] req_byte, ver_major, ver_minor, ver_update, first_suffix_char;
  logic [7:0] second_suffix_char, rsp_byte, rsp_type;
  logic [5:0] rsp_pos;
  logic [39:0] vin;
  logic [95:0] fw_name;
  logic [31:0] fw_version = 32'h0003_0217, mfr_enterprise = 32'h0000_A5A5;
  logic [15:0] host_device_ident = 16'h1AB0, host_vendor_ident = 16'h2CD1;
  logic [15:0] host_subsystem_ident = 16'h3EF2, host_subsystem_vendor_ident = 16'h4A53;
  int failures = 0;
  int checked = 0;
  assign {ver_major, ver_minor, ver_update, first_suffix_char, second_suffix_char} = vin;
  always #2.5 ref_clk = ~ref_clk;
  vir_responder dut (.*);
  vir_mc_model mc (.*);
  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %b got %b", n, e, g);
    end
  endtask
  task automatic quiet(string n);
    logic s;
    s = 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      s |= rsp_valid | cap_request;
    end
    chk1(n, 1'b0, s);
    $display("test %s done", n);
  endtask
  task automatic run_row(vir_row_s r);
    logic [319:0] b;
    vin = r.vin;
    host_if_shared = r.shared;
    mfr_used = r.mfr;
    fw_name = r.shared ? "ABCDEFGHIJKL" : {"fw", 8'h00, "junkjunkj"};
    mc.send(8'h15, 1'b0);
    for (int i = 0; i < 400 && !mc.fin; i++) begin
      @(posedge ref_clk);
      #1;
    end
    if (!mc.fin) begin
      failures++;
      summarize();
    end
    // name tail after the terminator reads as zero
    b = {32'h0, r.vexp[39:8], 24'h0, r.vexp[7:0], r.shared ? fw_name : {"fw", 80'h0},
         fw_version, r.shared ? {host_device_ident, host_vendor_ident, host_subsystem_ident,
         host_subsystem_vendor_ident} : 64'h0, r.mfr ? mfr_enterprise : 32'hFFFF_FFFF};
    for (int p = 16; p < 56; p++)
      chk8($sformatf("byte %0d", p), b[319-8*(p-16) -: 8], mc.got[p]);
    chk8("type", 8'h95, rsp_type);
    chk1("no fault", 1'b0, version_fault);
    $display("test row done");
  endtask
  initial begin
    vin = 40'hF1_F0FF_0000;
    fw_name = "ABCDEFGHIJKL";
    host_if_shared = 1'b0;
    mfr_used = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1;
    rst = 1'b0;
    chk8("type after reset", 8'h00, rsp_type);
    foreach (ROWS[i]) run_row(ROWS[i]);
    mc.slow = 1'b1;
    run_row(ROWS[2]);
    mc.slow = 1'b0;
    mc.send(8'h15, 1'b1);
    quiet("error");
    mc.send(8'h16, 1'b0);
    chk1("cap", 1'b1, cap_request);
    quiet("cap");
    mc.send(8'h14, 1'b0);
    quiet("other");
    vin = 40'hFF_01FF_0000;
    @(posedge ref_clk);
    #1;
    chk1("fault", 1'b1, version_fault);
    vin = 40'hF1_0AFF_0000;
    @(posedge ref_clk);
    #1;
    chk1("fault bcd", 1'b1, version_fault);
    rst = 1'b1;
    #1;
    chk8("type in reset", 8'h00, rsp_type);
    summarize();
  end
endmodule
`default_nettype wire

// ===== test/vir_mc_model.sv
// Purpose: management side, sends requests and sinks the reply
// Assumes: drives 1 ns after each rising edge
// Notes:   slow makes ready toggle every cycle
`timescale 1ns/1ps
`default_nettype none
module vir_mc_model (
  input  wire logic       ref_clk,
  input  wire logic       rsp_valid,
  input  wire logic [7:0] rsp_byte,
  input  wire logic [5:0] rsp_pos,
  input  wire logic       rsp_last,
  output logic            req_valid,
  output logic            req_start,
  output logic      [7:0] req_byte,
  output logic            req_done,
  output logic            req_error,
  output logic            rsp_ready
);
  logic       slow = 1'b0;
  logic       fin = 1'b0;
  logic [7:0] got [64];
  initial begin
    {req_valid, req_start, req_done, req_error, rsp_ready} = 5'h0;
    req_byte = 8'h00;
  end
  // header, code at byte 4, checksum and pad
  task automatic send(input logic [7:0] cmd, input logic err);
    for (int i = 0; i < 46; i++) begin
      req_valid = 1'b1;
      req_start = (i == 0);
      req_byte = (i == 4) ? cmd : 8'(i);
      @(posedge ref_clk);
      #1;
    end
    req_valid = 1'b0;
    req_byte = ~req_byte;
    req_done = 1'b1;
    req_error = err;
    @(posedge ref_clk);
    #1;
    req_done = 1'b0;
    req_error = 1'b0;
  endtask
  // a new request clears the capture, so a byte never sent shows as unknown
  always @(posedge ref_clk) begin
    if (req_valid && req_start) begin
      fin = 1'b0;
      foreach (got[k]) got[k] = 8'hxx;
    end
    if (rsp_valid && rsp_ready) begin
      got[rsp_pos] = rsp_byte;
      if (rsp_last) fin = 1'b1;
    end
    #1;
    rsp_ready = slow ? ~rsp_ready : 1'b1;
  end
endmodule
`default_nettype wire

// ===== test/vir_responder_asserts.sv
// Purpose: port checker for the version-id responder
// Assumes: one clock domain, async active-high reset
// Notes:   framing of the body is checked per byte slot
`timescale 1ns/1ps
`default_nettype none
module vir_chk (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       req_done,
  input wire logic       req_error,
  input wire logic       host_if_shared,
  input wire logic       mfr_used,
  input wire logic       rsp_ready,
  input wire logic       rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic [5:0] rsp_pos,
  input wire logic       rsp_last,
  input wire logic [7:0] rsp_type,
  input wire logic       cap_request
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_type_set: assert property (rsp_valid |-> rsp_type == 8'h95)
    else $error("response type wrong");
  // idle is known when neither this nor the last cycle offered a byte and
  // no done strobe came just before: a hold cycle always follows one of those
  a_err_quiet: assert property (
    req_done && req_error && !rsp_valid && !$past(rsp_valid) && !$past(req_done)
    |=> !cap_request ##1 !rsp_valid)
    else $error("answer after bad request");
  a_rsp_hold: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte) && $stable(rsp_pos))
    else $error("byte not held");
  a_pos_step: assert property (
    rsp_valid && rsp_ready && !rsp_last |=>
    !rsp_valid && rsp_pos == $past(rsp_pos) + 6'h1 ##1 rsp_valid)
    else $error("position step wrong");
  a_last_pos: assert property (rsp_last == (rsp_valid && rsp_pos == 6'h37))
    else $error("last flag wrong");
  a_zero_fill: assert property (
    rsp_valid && rsp_pos inside {[6'h10:6'h13], [6'h18:6'h1A]} |-> rsp_byte == 8'h00)
    else $error("code or reserved byte not zero");
  a_pci_zero: assert property (
    rsp_valid && !host_if_shared && rsp_pos inside {[6'h2C:6'h33]} |-> rsp_byte == 8'h00)
    else $error("host ident not zero");
  a_mfr_ones: assert property (
    rsp_valid && !mfr_used && rsp_pos inside {[6'h34:6'h37]} |-> rsp_byte == 8'hFF)
    else $error("maker field not all ones");
endmodule
bind vir_responder vir_chk u_chk (.*);
`default_nettype wire
